/* design/sil_regs.svh */
// timing constants and apb register map of the status indicator lamp driver
`ifndef SIL_REGS_SVH
`define SIL_REGS_SVH
`define SIL_CLK_MHZ 100
`define SIL_MS_CYCLES (`SIL_CLK_MHZ * 1000)
`define SIL_T_FLICKER_MS 50
`define SIL_T_FLASH_MS 200
`define SIL_T_PAUSE_MS 1000
`define SIL_T_FLICKER_TICKS `SIL_T_FLICKER_MS
`define SIL_T_FLASH_TICKS `SIL_T_FLASH_MS
`define SIL_T_PAUSE_TICKS `SIL_T_PAUSE_MS
`define SIL_ACT_HOLD_MS 50
`define SIL_ADDR_CTRL 12'h000
`define SIL_ADDR_STAT 12'h004
`define SIL_ADDR_IRQ_STAT 12'h008
`define SIL_ADDR_IRQ_MASK 12'h00C
`define SIL_CTRL_RESET 32'h0000_0000
`define SIL_MASK_RESET 8'h00
// event levels assumed at reset: link absent, so power-up is not reported as link lost
`define SIL_EV_IDLE 8'h40
`define SIL_ALS_CHANGE_ERR 8'h01
`endif

/* design/sil_pkg.sv */
// types shared by the status indicator lamp driver
package sil_pkg;
   // one tricolour lamp: green, red, blue drives
   typedef struct packed {
      logic green;
      logic red;
      logic blue;
   } sil_lamp_t;

   // slave state as reported by the network controller
   typedef enum logic [2:0] {
      SIL_NS_INIT,
      SIL_NS_PREOP,
      SIL_NS_SAFEOP,
      SIL_NS_OP,
      SIL_NS_BOOT,
      SIL_NS_BOOTING,
      SIL_NS_FWDL
   } sil_net_state_t;

   // lamp pattern to be shown
   typedef enum logic [2:0] {
      SIL_PAT_OFF,
      SIL_PAT_ON,
      SIL_PAT_BLINK,
      SIL_PAT_FLICKER,
      SIL_PAT_SINGLE,
      SIL_PAT_DOUBLE
   } sil_pat_t;

   // drive status inputs
   typedef struct packed {
      logic bus_power;
      logic drive_enabled;
      logic drive_fault;
      logic logic_supply_ok;
      logic emu_enc_active;
      logic [3:0] dig_in;
      logic [2:0] dig_out;
   } sil_drive_stat_t;

   // network status inputs
   typedef struct packed {
      logic link_valid;
      logic link_activity;
      sil_net_state_t state;
      logic process_data_interface_wdog;
      logic config_error;
      logic boot_error;
      logic [7:0] application_layer_change;
      logic app_wdog_timeout;
   } sil_net_stat_t;

   // all lamp outputs
   typedef struct packed {
      sil_lamp_t bridge;
      sil_lamp_t logic_supply;
      sil_lamp_t encoder_emulation;
      logic [3:0] input_state;
      logic [2:0] output_state;
      logic link;
      logic run;
      logic error;
   } sil_lamps_t;

   // apb slave signals
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } sil_apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } sil_apb_rsp_t;
endpackage : sil_pkg

/* design/sil_lamp_driver.sv */
// status indicator lamp driver: drive, i/o and network lamps with apb status
//
// Summary of operation
// - bridge lamp green powered+enabled, red on fault
// - logic supply lamp green while supply present
// - encoder emulation lamp green only when active
// - one green lamp per digital input
// - one blue lamp per digital output
// - link lamp: on, flicker on traffic, off
// - run lamp steady green when operational
// - run lamp blinks 200/200 ms in pre-op
// - run lamp single flash in safe-op
// - run lamp flickers 50/50 ms while booting
// - run lamp off in init
// - error lamp steady red on interface watchdog
// - error lamp blinks on configuration error
// - error lamp flickers on boot error in init with an autonomous change error
// - error lamp single flash on autonomous change
// - error lamp double flash on app watchdog
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "sil_regs.svh"
module sil_lamp_driver (
   input wire logic pclk,
   input wire logic presetn,
   input wire sil_pkg::sil_drive_stat_t drive_stat,
   input wire sil_pkg::sil_net_stat_t net_stat,
   input wire sil_pkg::sil_apb_req_t apb_req,
   output sil_pkg::sil_apb_rsp_t apb_rsp,
   output sil_pkg::sil_lamps_t lamps,
   output logic irq
);
   import sil_pkg::*;

   // =====================================================================
   // state
   // =====================================================================
   typedef struct packed {
      logic [16:0] pre_cnt;
      logic [10:0] run_ph;
      logic [10:0] err_ph;
      logic [6:0] act_ph;
      logic act_hold;
      sil_pat_t run_pat;
      sil_pat_t err_pat;
      logic [31:0] ctrl;
      logic [7:0] irq_stat;
      logic [7:0] irq_mask;
      logic [7:0] ev_prev;
      sil_apb_rsp_t rsp;
      sil_lamps_t lamps;
      logic irq;
   } sil_state_t;

   sil_state_t st_ff;
   sil_state_t nxt_st;

   // =====================================================================
   // pattern evaluation
   // =====================================================================
   // lamp level for pattern at phase (ms within period)
   function automatic logic pat_level(input sil_pat_t pat, input logic [10:0] ph);
      logic lvl;
      lvl = 1'b0;
      unique case (pat)
         SIL_PAT_OFF: lvl = 1'b0;
         SIL_PAT_ON: lvl = 1'b1;
         SIL_PAT_BLINK: lvl = (ph < 11'(`SIL_T_FLASH_TICKS));
         SIL_PAT_FLICKER: lvl = (ph < 11'(`SIL_T_FLICKER_TICKS));
         SIL_PAT_SINGLE: lvl = (ph < 11'(`SIL_T_FLASH_TICKS));
         SIL_PAT_DOUBLE: lvl = (ph < 11'(`SIL_T_FLASH_TICKS))
            || (ph >= 11'(2 * `SIL_T_FLASH_TICKS) && ph < 11'(3 * `SIL_T_FLASH_TICKS));
         default: lvl = 1'b0;
      endcase
      return lvl;
   endfunction : pat_level

   // last phase value of each pattern's period
   function automatic logic [10:0] pat_last(input sil_pat_t pat);
      logic [10:0] lst;
      lst = 11'h000;
      unique case (pat)
         SIL_PAT_BLINK: lst = 11'(2 * `SIL_T_FLASH_TICKS - 1);
         SIL_PAT_FLICKER: lst = 11'(2 * `SIL_T_FLICKER_TICKS - 1);
         SIL_PAT_SINGLE: lst = 11'(`SIL_T_FLASH_TICKS + `SIL_T_PAUSE_TICKS - 1);
         SIL_PAT_DOUBLE: lst = 11'(3 * `SIL_T_FLASH_TICKS + `SIL_T_PAUSE_TICKS - 1);
         default: lst = 11'h000;
      endcase
      return lst;
   endfunction : pat_last

   // phase advance on the ms tick, restart from first lit phase on change
   function automatic logic [10:0] ph_step(input sil_pat_t cur, input sil_pat_t nxt,
                                           input logic [10:0] ph, input logic tick);
      logic [10:0] r;
      r = ph;
      if (cur != nxt) begin
         r = 11'h000;
      end else if (tick) begin
         r = (ph >= pat_last(cur)) ? 11'h000 : 11'(ph + 11'h001);
      end
      return r;
   endfunction : ph_step

   // =====================================================================
   // next state
   // =====================================================================
   logic ms_tick;
   sil_pat_t run_sel;
   sil_pat_t err_sel;
   logic [7:0] events;
   logic apb_acc;
   logic [31:0] rd_data;

   always_comb begin
      nxt_st = st_ff;
      // free-running millisecond enable
      ms_tick = (st_ff.pre_cnt == 17'(`SIL_MS_CYCLES - 1));
      nxt_st.pre_cnt = ms_tick ? 17'h00000 : 17'(st_ff.pre_cnt + 17'h00001);

      // run-state pattern selection
      unique case (net_stat.state)
         SIL_NS_OP: run_sel = SIL_PAT_ON;
         SIL_NS_PREOP: run_sel = SIL_PAT_BLINK;
         SIL_NS_SAFEOP: run_sel = SIL_PAT_SINGLE;
         SIL_NS_BOOT, SIL_NS_BOOTING, SIL_NS_FWDL: run_sel = SIL_PAT_FLICKER;
         SIL_NS_INIT: run_sel = SIL_PAT_OFF;
         default: run_sel = SIL_PAT_OFF;
      endcase

      // error pattern, most severe first; dark when nothing pending
      if (net_stat.process_data_interface_wdog) begin
         err_sel = SIL_PAT_ON;
      end else if (net_stat.app_wdog_timeout) begin
         err_sel = SIL_PAT_DOUBLE;
      end else if (net_stat.boot_error && net_stat.state == SIL_NS_INIT
                   && net_stat.application_layer_change == `SIL_ALS_CHANGE_ERR) begin
         err_sel = SIL_PAT_FLICKER;
      end else if (net_stat.application_layer_change == `SIL_ALS_CHANGE_ERR) begin
         err_sel = SIL_PAT_SINGLE;
      end else if (net_stat.config_error) begin
         err_sel = SIL_PAT_BLINK;
      end else begin
         err_sel = SIL_PAT_OFF;
      end

      nxt_st.run_ph = ph_step(st_ff.run_pat, run_sel, st_ff.run_ph, ms_tick);
      nxt_st.err_ph = ph_step(st_ff.err_pat, err_sel, st_ff.err_ph, ms_tick);
      nxt_st.run_pat = run_sel;
      nxt_st.err_pat = err_sel;

      // link traffic stretched into a 50/50 ms flicker so it is visible
      if (net_stat.link_activity) begin
         nxt_st.act_hold = 1'b1;
      end else if (ms_tick && st_ff.act_ph == 7'(2 * `SIL_ACT_HOLD_MS - 1)) begin
         nxt_st.act_hold = 1'b0;
      end
      // the 100 ms traffic period needs seven bits of phase
      if (!st_ff.act_hold) begin
         nxt_st.act_ph = 7'h00;
      end else if (ms_tick) begin
         nxt_st.act_ph = (st_ff.act_ph == 7'(2 * `SIL_ACT_HOLD_MS - 1)) ? 7'h00
                         : 7'(st_ff.act_ph + 7'h01);
      end

      // lamp outputs, all registered
      nxt_st.lamps.bridge.red = drive_stat.drive_fault;
      nxt_st.lamps.bridge.green = drive_stat.bus_power && drive_stat.drive_enabled
                                  && !drive_stat.drive_fault;
      nxt_st.lamps.bridge.blue = 1'b0;
      nxt_st.lamps.logic_supply = '{green: drive_stat.logic_supply_ok, red: 1'b0,
                                    blue: 1'b0};
      nxt_st.lamps.encoder_emulation = '{green: drive_stat.emu_enc_active, red: 1'b0,
                                         blue: 1'b0};
      nxt_st.lamps.input_state = drive_stat.dig_in;
      nxt_st.lamps.output_state = drive_stat.dig_out;
      nxt_st.lamps.link = net_stat.link_valid
                          && !(st_ff.act_hold && st_ff.act_ph >= 7'(`SIL_ACT_HOLD_MS));
      // pattern restarts lit: phase zero is shown when the pattern changes
      nxt_st.lamps.run = pat_level(run_sel, nxt_st.run_ph);
      nxt_st.lamps.error = pat_level(err_sel, nxt_st.err_ph);

      // sticky event bits: rising edges of fault and error conditions and of entering op
      events = {net_stat.state == SIL_NS_OP, !net_stat.link_valid, net_stat.config_error,
                net_stat.application_layer_change == `SIL_ALS_CHANGE_ERR,
                net_stat.boot_error, net_stat.app_wdog_timeout,
                net_stat.process_data_interface_wdog, drive_stat.drive_fault};
      nxt_st.ev_prev = events;

      // apb slave, zero wait states
      apb_acc = apb_req.psel && apb_req.penable;
      unique case (apb_req.paddr)
         `SIL_ADDR_CTRL: rd_data = st_ff.ctrl;
         `SIL_ADDR_STAT: rd_data = {21'h000000, 1'b0, st_ff.err_pat, 1'b0, st_ff.run_pat,
                                    st_ff.lamps.link, st_ff.lamps.run, st_ff.lamps.error};
         `SIL_ADDR_IRQ_STAT: rd_data = {24'h000000, st_ff.irq_stat};
         `SIL_ADDR_IRQ_MASK: rd_data = {24'h000000, st_ff.irq_mask};
         default: rd_data = 32'h0000_0000;
      endcase
      nxt_st.rsp.pready = apb_req.psel && !apb_req.penable;
      nxt_st.rsp.pslverr = 1'b0;
      nxt_st.rsp.prdata = st_ff.rsp.prdata;
      if (apb_req.psel && !apb_req.penable) begin
         nxt_st.rsp.prdata = apb_req.pwrite ? 32'h0000_0000 : rd_data;
         nxt_st.rsp.pslverr = !(apb_req.paddr == `SIL_ADDR_CTRL
                                || apb_req.paddr == `SIL_ADDR_STAT
                                || apb_req.paddr == `SIL_ADDR_IRQ_STAT
                                || apb_req.paddr == `SIL_ADDR_IRQ_MASK);
      end

      // write one clears; a new event in the same cycle wins
      nxt_st.irq_stat = st_ff.irq_stat;
      if (apb_acc && st_ff.rsp.pready && apb_req.pwrite) begin
         unique case (apb_req.paddr)
            `SIL_ADDR_CTRL: nxt_st.ctrl = apb_req.pwdata; // storage only, lamps never forced
            `SIL_ADDR_IRQ_STAT: nxt_st.irq_stat = st_ff.irq_stat & ~apb_req.pwdata[7:0];
            `SIL_ADDR_IRQ_MASK: nxt_st.irq_mask = apb_req.pwdata[7:0];
            default: nxt_st.irq_mask = st_ff.irq_mask;
         endcase
      end
      nxt_st.irq_stat = nxt_st.irq_stat | (events & ~st_ff.ev_prev);
      nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
   end

   // =====================================================================
   // registers
   // =====================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
         st_ff.ctrl <= `SIL_CTRL_RESET;
         st_ff.irq_mask <= `SIL_MASK_RESET;
         st_ff.ev_prev <= `SIL_EV_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign apb_rsp = st_ff.rsp;
   assign lamps = st_ff.lamps;
   assign irq = st_ff.irq;
endmodule : sil_lamp_driver

/* dv/sil_lamp_sva.sv */
// checker for the lamp driver ports
`timescale 1ns/1ps
module sil_lamp_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire sil_pkg::sil_drive_stat_t drive_stat,
   input wire sil_pkg::sil_net_stat_t net_stat,
   input wire sil_pkg::sil_apb_req_t apb_req,
   input wire sil_pkg::sil_apb_rsp_t apb_rsp,
   input wire sil_pkg::sil_lamps_t lamps,
   input wire logic irq
);
   import sil_pkg::*;
   logic [1:0] up_ff;
   logic [1:0] nxt_up;
   logic ok;
   logic br_ok;
   logic no_err;
   // edges since reset; outputs stay low through the first edge, so wait three
   always_comb nxt_up = (up_ff == 2'h3) ? up_ff : up_ff + 2'h1;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) up_ff <= 2'h0;
      else up_ff <= nxt_up;
   end
   // derived conditions
   assign ok = (up_ff == 2'h3);
   assign br_ok = drive_stat.bus_power & drive_stat.drive_enabled & ~drive_stat.drive_fault;
   assign no_err = !net_stat.process_data_interface_wdog && !net_stat.app_wdog_timeout &&
      (net_stat.application_layer_change != 8'h01) && !net_stat.config_error;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================
   // drive and i/o lamps
   input_lamps_a: assert property (
      ok |-> lamps.input_state == $past(drive_stat.dig_in)) else $error("input lamps wrong");
   output_lamps_a: assert property (
      ok && $stable(drive_stat.dig_out) |-> lamps.output_state == drive_stat.dig_out)
      else $error("output lamps wrong");
   bridge_red_a: assert property (
      ok && $past(drive_stat.drive_fault) |-> lamps.bridge.red && !lamps.bridge.green)
      else $error("bridge lamp not red on fault");
   bridge_green_a: assert property (
      ok && $past(br_ok) |-> lamps.bridge.green) else $error("bridge lamp not green");
   supply_lamp_a: assert property (
      ok |-> lamps.logic_supply.green == $past(drive_stat.logic_supply_ok))
      else $error("supply lamp wrong");
   encoder_dark_a: assert property (
      ok && !drive_stat.emu_enc_active |=> !lamps.encoder_emulation.green)
      else $error("encoder lamp lit");
   // ==========================================
   // network lamps
   link_off_a: assert property (
      ok && !net_stat.link_valid |=> !lamps.link) else $error("link lamp lit");
   run_op_a: assert property (
      (ok && net_stat.state == SIL_NS_OP) [*2] |=> lamps.run) else $error("run lamp dark");
   run_init_a: assert property (
      (ok && net_stat.state == SIL_NS_INIT) [*2] |=> !lamps.run) else $error("run lamp lit");
   run_restart_a: assert property (
      ok && $changed(net_stat.state) && net_stat.state inside {SIL_NS_PREOP, SIL_NS_SAFEOP,
      SIL_NS_OP, SIL_NS_BOOT, SIL_NS_BOOTING, SIL_NS_FWDL} && !(net_stat.state inside
      {SIL_NS_BOOT, SIL_NS_BOOTING, SIL_NS_FWDL} && $past(net_stat.state) inside
      {SIL_NS_BOOT, SIL_NS_BOOTING, SIL_NS_FWDL}) |-> ##[1:2] lamps.run)
      else $error("pattern not restarted lit");
   err_steady_a: assert property (
      (ok && net_stat.process_data_interface_wdog) [*2] |=> lamps.error)
      else $error("error lamp dark");
   err_dark_a: assert property (
      (ok && no_err) [*2] |=> !lamps.error) else $error("error lamp lit");
   // ==========================================
   // register bus handshake
   pready_due_a: assert property (
      ok && apb_req.psel && !apb_req.penable |=> apb_rsp.pready) else $error("no pready");
   pready_only_a: assert property (
      apb_rsp.pready |-> apb_req.psel && apb_req.penable) else $error("stray pready");
   cover property (lamps.error && net_stat.process_data_interface_wdog);
   cover property (lamps.bridge.red);
   cover property (irq);
endmodule : sil_lamp_sva

bind sil_lamp_driver sil_lamp_sva i_sva (.pclk(pclk), .presetn(presetn),
   .drive_stat(drive_stat), .net_stat(net_stat), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .lamps(lamps), .irq(irq));

/* dv/sil_operator.sv */
// operator model watching the panel
`timescale 1ns/1ps
module sil_operator (
   input wire logic pclk,
   input wire sil_pkg::sil_lamps_t lamps,
   output sil_pkg::sil_lamps_t view
);
   import sil_pkg::*;
   // ==========================================
   // viewing
   // a one-clock lag stands in for the eye, so checks must settle first
   always_ff @(posedge pclk) view <= lamps;
endmodule : sil_operator

/* dv/tb_top.sv */
// self-checking bench for the lamp driver
`timescale 1ns/1ps
`include "sil_regs.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
   $display("unexpected t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_top;
   import sil_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   sil_drive_stat_t ds = '0;
   sil_net_stat_t ns = '0;
   sil_apb_req_t req = '0;
   sil_apb_rsp_t rsp;
   sil_lamps_t lamps;
   sil_lamps_t view;
   logic irq;
   logic [31:0] q;
   logic e;
   int n_mismatch = 0;
   int compares = 0;
   int cyc = 0;
   sil_lamp_driver i_dut (.pclk(pclk), .presetn(presetn), .drive_stat(ds), .net_stat(ns),
      .apb_req(req), .apb_rsp(rsp), .lamps(lamps), .irq(irq));
   sil_operator i_op (.pclk(pclk), .lamps(lamps), .view(view));
   // ==========================================
   // clock and hang guard
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         close_out();
      end
   end
   // ==========================================
   // shared tasks
   task automatic close_out();
      $display("mismatches=%0d compares=%0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : close_out
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : wt
   // request held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge pclk);
      req.penable <= 1'b1;
      @(posedge pclk);
      while (rsp.pready !== 1'b1) @(posedge pclk);
      q = rsp.prdata;
      e = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb
   // ==========================================
   // scenarios
   task automatic t_drive();
      @(posedge pclk);
      ds <= '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 4'hA, 3'h5};
      wt(4);
      `CHK(view.bridge, 3'h4)
      `CHK(view.logic_supply, 3'h4)
      `CHK(view.encoder_emulation, 3'h4)
      `CHK({view.input_state, view.output_state}, 7'h55)
      @(posedge pclk);
      ds <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 4'h5, 3'h2};
      wt(4);
      `CHK(view.bridge, 3'h2)
      `CHK(view.logic_supply, 3'h0)
      `CHK(view.encoder_emulation, 3'h0)
      `CHK({view.input_state, view.output_state}, 7'h2A)
   endtask : t_drive
   task automatic t_link();
      @(posedge pclk);
      ns.link_activity <= 1'b1;
      wt(3);
      `CHK(lamps.link, 1'b0)
      @(posedge pclk);
      ns.link_valid <= 1'b1;
      wt(3);
      `CHK(lamps.link, 1'b1)
      @(posedge pclk);
      ns.link_activity <= 1'b0;
      wt(3);
      `CHK(lamps.link, 1'b1)
   endtask : t_link
   task automatic t_run();
      sil_net_state_t st [7] = '{SIL_NS_INIT, SIL_NS_PREOP, SIL_NS_SAFEOP, SIL_NS_OP,
         SIL_NS_BOOT, SIL_NS_BOOTING, SIL_NS_FWDL};
      sil_pat_t p [7] = '{SIL_PAT_OFF, SIL_PAT_BLINK, SIL_PAT_SINGLE, SIL_PAT_ON,
         SIL_PAT_FLICKER, SIL_PAT_FLICKER, SIL_PAT_FLICKER};
      for (int i = 0; i < 7; i++) begin
         @(posedge pclk);
         ns.state <= st[i];
         wt(3);
         `CHK(lamps.run, (i != 0))
         apb(1'b0, `SIL_ADDR_STAT, 32'h0);
         `CHK(q[5:3], p[i])
      end
   endtask : t_run
   // each step adds a more severe error, so only the newest one may show
   task automatic t_err();
      sil_net_stat_t c [6];
      sil_pat_t p [6] = '{SIL_PAT_OFF, SIL_PAT_BLINK, SIL_PAT_SINGLE, SIL_PAT_FLICKER,
         SIL_PAT_DOUBLE, SIL_PAT_ON};
      c[0] = '0;
      c[0].state = SIL_NS_PREOP;
      c[1] = c[0];
      c[1].config_error = 1'b1;
      c[2] = c[1];
      c[2].application_layer_change = `SIL_ALS_CHANGE_ERR;
      c[3] = c[2];
      c[3].state = SIL_NS_INIT;
      c[3].boot_error = 1'b1;
      c[4] = c[3];
      c[4].app_wdog_timeout = 1'b1;
      c[5] = c[4];
      c[5].process_data_interface_wdog = 1'b1;
      for (int i = 0; i < 6; i++) begin
         @(posedge pclk);
         ns <= c[i];
         wt(3);
         `CHK(lamps.error, (i != 0))
         apb(1'b0, `SIL_ADDR_STAT, 32'h0);
         `CHK(q[9:7], p[i])
      end
   endtask : t_err
   task automatic t_regs();
      apb(1'b0, `SIL_ADDR_CTRL, 32'h0);
      `CHK({e, q}, {1'b0, `SIL_CTRL_RESET})
      apb(1'b1, `SIL_ADDR_CTRL, 32'hA5C3_0F96);
      apb(1'b0, `SIL_ADDR_CTRL, 32'h0);
      `CHK({e, q}, {1'b0, 32'hA5C3_0F96})
      apb(1'b0, `SIL_ADDR_IRQ_MASK, 32'h0);
      `CHK(q[7:0], `SIL_MASK_RESET)
      apb(1'b1, 12'h010, 32'hFFFF_FFFF);
      apb(1'b0, 12'h010, 32'h0);
      `CHK({e, q}, {1'b1, 32'h0})
   endtask : t_regs
   // a set mask bit lets the matching status bit onto irq
   task automatic t_irq();
      @(posedge pclk);
      ds.drive_fault <= 1'b0;
      wt(2);
      apb(1'b1, `SIL_ADDR_IRQ_MASK, 32'h0000_0001);
      apb(1'b1, `SIL_ADDR_IRQ_STAT, 32'h0000_00FF);
      wt(2);
      `CHK(irq, 1'b0)
      @(posedge pclk);
      ds.drive_fault <= 1'b1;
      wt(3);
      apb(1'b0, `SIL_ADDR_IRQ_STAT, 32'h0);
      `CHK(q[7:0], 8'h01)
      wt(1);
      `CHK(irq, 1'b1)
      apb(1'b1, `SIL_ADDR_IRQ_MASK, 32'h0);
      wt(2);
      `CHK(irq, 1'b0)
      apb(1'b1, `SIL_ADDR_IRQ_MASK, 32'h0000_0001);
      apb(1'b1, `SIL_ADDR_IRQ_STAT, 32'h0000_0001);
      wt(2);
      `CHK(irq, 1'b0)
      // link gained then lost: only the loss is an event
      @(posedge pclk);
      ns.link_valid <= 1'b1;
      wt(2);
      @(posedge pclk);
      ns.link_valid <= 1'b0;
      wt(2);
      apb(1'b0, `SIL_ADDR_IRQ_STAT, 32'h0);
      `CHK(q[7:0], 8'h40)
   endtask : t_irq
   // ==========================================
   // main sequence
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_drive();
      t_link();
      t_run();
      t_err();
      t_regs();
      t_irq();
      close_out();
   end
endmodule : tb_top
